// ---- logic/scc_clock_port.sv ----
`timescale 1ns/100ps
// Functional notes
// - time of day, weekday and month kept in a 40-bit shift register on bit 0
// - register holds eight BCD nibbles, a weekday nibble, then one hex month nibble
// - shift is LSB first both ways, seconds units first, month MSB last
// - seconds bits 1-8, minutes 9-16, hours 17-24, units nibble first
// - day of month 25-32, weekday 33-36, month 37-40 zero based
// - once loaded the clock advances time and date by itself
// - every month treated as 31 days long
// - forty bits read, each bit shown on input bit 0
// - latched pulse request drives interrupt request line seven, level type
// - timed pulse is a 50% square wave at 64, 256 or 2048 Hz, or 32 Hz in test mode
// - a read of the clock port (PORT_OFFSET) clears the pending timed request
// - request held in a flip-flop as a steady level until cleared
// - request set on rising edge of the timed pulse
// - timed pulse level readable any time on input bit 1
// - outputs: data, shift clock, command bits, strobe; inputs: data out, pulse
// - command codes: hold, shift, set, read, 64, 256, 2048 Hz, test 32 Hz
// - powers up in 32 Hz test mode; clock commands ignored until rate set
// - data shifted in on shift clock rise, next bit shown on fall
module scc_clock_port #(
    parameter int CLK_HZ = scc_pkg::CLK_HZ
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic [2:0] port_addr,
    input  wire logic       port_wr,
    input  wire logic       port_rd,
    input  wire logic [7:0] port_wdata,
    output logic      [7:0] port_rdata_q,
    output logic            timed_pulse_q,
    output logic            request_line_seven_q
);
    logic [scc_pkg::PRESC_W-1:0] div_q;
    logic                        sec_tick_q;

    scc_prescale #(.CLK_HZ(CLK_HZ)) u_presc (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .div_q      (div_q),
        .sec_tick_q (sec_tick_q)
    );

    function automatic logic [7:0] bcd_next(input logic [7:0] v, input logic [7:0] top,
                                            input logic [7:0] bottom);
        if (v == top)
            return bottom;
        else if (v[3:0] == scc_pkg::BCD_NINE)
            return {v[7:4] + 4'h1, scc_pkg::NIB_ZERO};
        else
            return v + 8'h01;
    endfunction : bcd_next

    function automatic logic [3:0] hex_next(input logic [3:0] v, input logic [3:0] top);
        return (v == top) ? scc_pkg::NIB_ZERO : v + 4'h1;
    endfunction : hex_next

    logic                     sel_wr;
    logic                     sel_rd;
    logic                     strobe_q, strobe_d;
    logic                     sclk_q, sclk_d;
    logic                     din_q, din_d;
    logic [2:0]               cmd_q, cmd_d;
    logic                     shift_en_q, shift_en_d;
    logic                     test_q, test_d;
    scc_pkg::scc_rate_e       rate_q, rate_d;
    logic [scc_pkg::TIME_W-1:0] sreg_q, sreg_d;
    logic [scc_pkg::TIME_W-1:0] now_q, now_d;
    logic                     dout_q, dout_d;
    logic                     tp_d;
    logic                     req_d;
    logic [7:0]               rdata_d;
    logic                     strobe_rise, sclk_rise, sclk_fall;
    logic                     cmd_go;
    logic                     c_sec, c_min, c_hour, c_day;

    assign sel_wr = port_wr && (port_addr == scc_pkg::PORT_OFFSET);
    assign sel_rd = port_rd && (port_addr == scc_pkg::PORT_OFFSET);

    // port output latch
    always_comb begin
        strobe_d = strobe_q;
        sclk_d   = sclk_q;
        din_d    = din_q;
        cmd_d    = cmd_q;
        if (sel_wr) begin
            din_d    = port_wdata[scc_pkg::BIT_DIN];
            sclk_d   = port_wdata[scc_pkg::BIT_SCLK];
            cmd_d    = port_wdata[scc_pkg::BIT_CMD_LSB +: 3];
            strobe_d = port_wdata[scc_pkg::BIT_STROBE];
        end
    end

    assign strobe_rise = strobe_d && !strobe_q;
    assign sclk_rise   = sclk_d && !sclk_q;
    assign sclk_fall   = !sclk_d && sclk_q;
    // clock commands only after a real pulse rate was chosen
    assign cmd_go      = strobe_rise && (cmd_d[2] || !test_q);

    // command decode, shift register and running calendar
    always_comb begin
        shift_en_d = shift_en_q;
        test_d     = test_q;
        rate_d     = rate_q;
        sreg_d     = sreg_q;
        now_d      = now_q;
        dout_d     = dout_q;
        c_sec      = 1'b0;
        c_min      = 1'b0;
        c_hour     = 1'b0;
        c_day      = 1'b0;
        if (sec_tick_q) begin
            c_sec  = now_q[scc_pkg::SEC_LSB +: 8] == scc_pkg::SEC_MAX;
            c_min  = c_sec && (now_q[scc_pkg::MIN_LSB +: 8] == scc_pkg::MIN_MAX);
            c_hour = c_min && (now_q[scc_pkg::HOUR_LSB +: 8] == scc_pkg::HOUR_MAX);
            c_day  = c_hour && (now_q[scc_pkg::DAY_LSB +: 8] == scc_pkg::DAY_MAX);
            now_d[scc_pkg::SEC_LSB +: 8] =
                bcd_next(now_q[scc_pkg::SEC_LSB +: 8], scc_pkg::SEC_MAX, scc_pkg::ZERO_BCD);
            if (c_sec)
                now_d[scc_pkg::MIN_LSB +: 8] =
                    bcd_next(now_q[scc_pkg::MIN_LSB +: 8], scc_pkg::MIN_MAX, scc_pkg::ZERO_BCD);
            if (c_min)
                now_d[scc_pkg::HOUR_LSB +: 8] =
                    bcd_next(now_q[scc_pkg::HOUR_LSB +: 8], scc_pkg::HOUR_MAX, scc_pkg::ZERO_BCD);
            if (c_hour) begin
                now_d[scc_pkg::DAY_LSB +: 8] =
                    bcd_next(now_q[scc_pkg::DAY_LSB +: 8], scc_pkg::DAY_MAX, scc_pkg::DAY_MIN);
                now_d[scc_pkg::WDAY_LSB +: 4] =
                    hex_next(now_q[scc_pkg::WDAY_LSB +: 4], scc_pkg::WDAY_MAX);
            end
            if (c_day)
                now_d[scc_pkg::MON_LSB +: 4] =
                    hex_next(now_q[scc_pkg::MON_LSB +: 4], scc_pkg::MON_MAX);
        end
        if (cmd_go) begin
            shift_en_d = 1'b0;
            case (scc_pkg::scc_cmd_e'(cmd_d))
                scc_pkg::SCC_CMD_HOLD:  shift_en_d = 1'b0;
                scc_pkg::SCC_CMD_SHIFT: shift_en_d = 1'b1;
                scc_pkg::SCC_CMD_SET:   now_d = sreg_q;
                scc_pkg::SCC_CMD_READ: begin
                    sreg_d = now_q;
                    dout_d = now_q[0];
                end
                scc_pkg::SCC_CMD_TP64: begin
                    rate_d = scc_pkg::SCC_RATE_64;
                    test_d = 1'b0;
                end
                scc_pkg::SCC_CMD_TP256: begin
                    rate_d = scc_pkg::SCC_RATE_256;
                    test_d = 1'b0;
                end
                scc_pkg::SCC_CMD_TP2K: begin
                    rate_d = scc_pkg::SCC_RATE_2K;
                    test_d = 1'b0;
                end
                default: begin
                    rate_d = scc_pkg::SCC_RATE_TEST;
                    test_d = 1'b1;
                end
            endcase
        end else if (shift_en_q && sclk_rise) begin
            sreg_d = {din_d, sreg_q[scc_pkg::TIME_W-1:1]};
        end else if (shift_en_q && sclk_fall) begin
            dout_d = sreg_q[0];
        end
    end

    // timed pulse, request latch, read data
    always_comb begin
        case (rate_q)
            scc_pkg::SCC_RATE_64:   tp_d = div_q[scc_pkg::TAP_64];
            scc_pkg::SCC_RATE_256:  tp_d = div_q[scc_pkg::TAP_256];
            scc_pkg::SCC_RATE_2K:   tp_d = div_q[scc_pkg::TAP_2048];
            default:                tp_d = div_q[scc_pkg::TAP_32];
        endcase
        req_d = request_line_seven_q;
        if (sel_rd)
            req_d = 1'b0;
        if (tp_d && !timed_pulse_q)
            req_d = 1'b1;
        rdata_d = 8'h00;
        rdata_d[scc_pkg::BIT_DOUT] = dout_q;
        rdata_d[scc_pkg::BIT_TP]   = timed_pulse_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strobe_q             <= 1'b0;
            sclk_q               <= 1'b0;
            din_q                <= 1'b0;
            cmd_q                <= 3'h0;
            shift_en_q           <= 1'b0;
            test_q               <= 1'b1;
            rate_q               <= scc_pkg::SCC_RATE_TEST;
            sreg_q               <= '0;
            now_q                <= scc_pkg::TIME_RESET;
            dout_q               <= 1'b0;
            timed_pulse_q        <= 1'b0;
            request_line_seven_q <= 1'b0;
            port_rdata_q         <= 8'h00;
        end else begin
            strobe_q             <= strobe_d;
            sclk_q               <= sclk_d;
            din_q                <= din_d;
            cmd_q                <= cmd_d;
            shift_en_q           <= shift_en_d;
            test_q               <= test_d;
            rate_q               <= rate_d;
            sreg_q               <= sreg_d;
            now_q                <= now_d;
            dout_q               <= dout_d;
            timed_pulse_q        <= tp_d;
            request_line_seven_q <= req_d;
            port_rdata_q         <= rdata_d;
        end
    end

    property p_req_set;
        @(posedge clk_sys) disable iff (!rst_n)
            $rose(timed_pulse_q) |-> request_line_seven_q;
    endproperty
    a_req_set: assert property (p_req_set) else $error("request not set on pulse rise");

    property p_req_clear;
        @(posedge clk_sys) disable iff (!rst_n)
            (sel_rd && !(tp_d && !timed_pulse_q)) |=> !request_line_seven_q;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("port read did not clear request");

    property p_req_hold;
        @(posedge clk_sys) disable iff (!rst_n)
            (request_line_seven_q && !sel_rd) |=> request_line_seven_q;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped without read");

    property p_test_block;
        @(posedge clk_sys) disable iff (!rst_n)
            (test_q && strobe_rise && !cmd_d[2]) |=> (now_q == $past(now_q) || $past(sec_tick_q))
                && sreg_q == $past(sreg_q);
    endproperty
    a_test_block: assert property (p_test_block) else $error("clock command ran in test mode");

    property p_shift_in;
        @(posedge clk_sys) disable iff (!rst_n)
            (shift_en_q && sclk_rise && !strobe_rise)
                |=> sreg_q == {$past(din_d), $past(sreg_q[scc_pkg::TIME_W-1:1])};
    endproperty
    a_shift_in: assert property (p_shift_in) else $error("shift register did not take data bit");

    property p_read_cmd;
        @(posedge clk_sys) disable iff (!rst_n)
            (cmd_go && cmd_d == scc_pkg::SCC_CMD_READ) |=> sreg_q == $past(now_q) ##1 port_rdata_q[0] == sreg_q[0];
    endproperty
    a_read_cmd: assert property (p_read_cmd) else $error("read command did not copy time");

    property p_set_cmd;
        @(posedge clk_sys) disable iff (!rst_n)
            (cmd_go && cmd_d == scc_pkg::SCC_CMD_SET) |=> now_q == $past(sreg_q);
    endproperty
    a_set_cmd: assert property (p_set_cmd) else $error("set command did not load clock");

    property p_tp_rate;
        @(posedge clk_sys) disable iff (!rst_n)
            (rate_q == scc_pkg::SCC_RATE_2K) |=> timed_pulse_q == $past(div_q[scc_pkg::TAP_2048]);
    endproperty
    a_tp_rate: assert property (p_tp_rate) else $error("pulse not at 2048 Hz tap");

    property p_rd_tp;
        @(posedge clk_sys) disable iff (!rst_n)
            ##1 port_rdata_q[scc_pkg::BIT_TP] == $past(timed_pulse_q) && port_rdata_q[7:2] == 6'h00;
    endproperty
    a_rd_tp: assert property (p_rd_tp) else $error("read data does not show pulse level");

    property p_dout_fall;
        @(posedge clk_sys) disable iff (!rst_n)
            (shift_en_q && sclk_fall && !strobe_rise) |=> dout_q == $past(sreg_q[0]);
    endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("next bit not shown on shift clock fall");

    property p_tick_step;
        @(posedge clk_sys) disable iff (!rst_n)
            (sec_tick_q && !cmd_go) |=> now_q != $past(now_q);
    endproperty
    a_tick_step: assert property (p_tick_step) else $error("calendar did not advance on tick");

    property p_idle_time;
        @(posedge clk_sys) disable iff (!rst_n)
            (!sec_tick_q && !cmd_go) |=> now_q == $past(now_q);
    endproperty
    a_idle_time: assert property (p_idle_time) else $error("calendar moved between ticks");

    property p_rate_pick;
        @(posedge clk_sys) disable iff (!rst_n)
            (cmd_go && cmd_d[2] && cmd_d != scc_pkg::SCC_CMD_TEST) |=> !test_q;
    endproperty
    a_rate_pick: assert property (p_rate_pick) else $error("pulse rate did not leave test mode");
endmodule : scc_clock_port

// ---- inc/scc_pkg.sv ----
package scc_pkg;
    localparam logic [2:0]  PORT_OFFSET   = 3'h2;
    localparam int          TIME_W        = 40;
    localparam int          CLK_HZ        = 25_000_000;
    localparam int          XTAL_HZ       = 32_768;
    localparam int          PRESC_W       = 15;
    // port output bit positions
    localparam int          BIT_DIN       = 0;
    localparam int          BIT_SCLK      = 1;
    localparam int          BIT_CMD_LSB   = 2;
    localparam int          BIT_STROBE    = 5;
    // port input bit positions
    localparam int          BIT_DOUT      = 0;
    localparam int          BIT_TP        = 1;
    // time register field positions
    localparam int          SEC_LSB       = 0;
    localparam int          MIN_LSB       = 8;
    localparam int          HOUR_LSB      = 16;
    localparam int          DAY_LSB       = 24;
    localparam int          WDAY_LSB      = 32;
    localparam int          MON_LSB       = 36;
    localparam logic [7:0]  SEC_MAX       = 8'h59;
    localparam logic [7:0]  MIN_MAX       = 8'h59;
    localparam logic [7:0]  HOUR_MAX      = 8'h23;
    localparam logic [7:0]  DAY_MAX       = 8'h31;
    localparam logic [7:0]  DAY_MIN       = 8'h01;
    localparam logic [7:0]  ZERO_BCD      = 8'h00;
    localparam logic [3:0]  WDAY_MAX      = 4'h6;
    localparam logic [3:0]  MON_MAX       = 4'hB;
    localparam logic [3:0]  NIB_ZERO      = 4'h0;
    localparam logic [3:0]  BCD_NINE      = 4'h9;
    localparam logic [39:0] TIME_RESET    = 40'h0_0_01_00_00_00;
    // prescaler tap for each pulse rate (half period in xtal ticks = 2^tap)
    localparam int          TAP_64        = 8;
    localparam int          TAP_256       = 6;
    localparam int          TAP_2048      = 3;
    localparam int          TAP_32        = 9;
    typedef enum logic [2:0] {
        SCC_CMD_HOLD  = 3'h0,
        SCC_CMD_SHIFT = 3'h1,
        SCC_CMD_SET   = 3'h2,
        SCC_CMD_READ  = 3'h3,
        SCC_CMD_TP64  = 3'h4,
        SCC_CMD_TP256 = 3'h5,
        SCC_CMD_TP2K  = 3'h6,
        SCC_CMD_TEST  = 3'h7
    } scc_cmd_e;
    typedef enum logic [1:0] {
        SCC_RATE_64   = 2'h0,
        SCC_RATE_256  = 2'h1,
        SCC_RATE_2K   = 2'h3,
        SCC_RATE_TEST = 2'h2
    } scc_rate_e;
endpackage : scc_pkg

// ---- logic/scc_prescale.sv ----
`timescale 1ns/100ps
module scc_prescale #(
    parameter int CLK_HZ = scc_pkg::CLK_HZ
) (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    output logic [scc_pkg::PRESC_W-1:0]     div_q,
    output logic                            sec_tick_q
);
    logic [31:0]                 acc_q;
    logic [31:0]                 acc_d;
    logic [scc_pkg::PRESC_W-1:0] div_d;
    logic                        sec_tick_d;

    // fractional accumulator: average xtal tick rate from the system clock
    always_comb begin
        acc_d      = acc_q + 32'(scc_pkg::XTAL_HZ);
        div_d      = div_q;
        sec_tick_d = 1'b0;
        if (acc_d >= 32'(CLK_HZ)) begin
            acc_d = acc_d - 32'(CLK_HZ);
            div_d = div_q + scc_pkg::PRESC_W'(1);
            sec_tick_d = &div_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_q      <= '0;
            div_q      <= '0;
            sec_tick_q <= 1'b0;
        end else begin
            acc_q      <= acc_d;
            div_q      <= div_d;
            sec_tick_q <= sec_tick_d;
        end
    end
endmodule : scc_prescale

// ---- bench/scc_clock_port_tb.sv ----
`timescale 1ns/100ps
module scc_clock_port_tb;
    localparam int SIM_HZ = 65536;
    logic        clk_sys;
    logic        rst_n;
    logic [2:0]  port_addr;
    logic        port_wr;
    logic        port_rd;
    logic [7:0]  port_wdata;
    logic [7:0]  port_rdata_q;
    logic        timed_pulse_q;
    logic        request_line_seven_q;
    logic [7:0]  hi;
    logic [39:0] t;
    logic [39:0] got;
    int          miscompares;
    int          comparisons;
    int          n;
    // by the port bit map 31h decodes as 64 Hz, 34h as 256 Hz, 38h as 2048 Hz, 3Ch as test
    logic [7:0]  sel_a [5] = '{8'h3C, 8'h30, 8'h31, 8'h34, 8'h38};
    logic [7:0]  sel_b [5] = '{8'h1C, 8'h10, 8'h11, 8'h14, 8'h18};
    int          half  [5] = '{1024, 512, 512, 128, 16};

    scc_clock_port #(.CLK_HZ(SIM_HZ)) uut (
        .clk_sys              (clk_sys),
        .rst_n                (rst_n),
        .port_addr            (port_addr),
        .port_wr              (port_wr),
        .port_rd              (port_rd),
        .port_wdata           (port_wdata),
        .port_rdata_q         (port_rdata_q),
        .timed_pulse_q        (timed_pulse_q),
        .request_line_seven_q (request_line_seven_q)
    );

    always #20 clk_sys = ~clk_sys;

    task automatic summarize;
        $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [39:0] g, input logic [39:0] e, input string what);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, g, e);
        end
    endtask : chk

    task automatic endt(input string name);
        $display("test %s done, %0d comparisons, %0d miscompares", name, comparisons, miscompares);
    endtask : endt

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic wr(input logic [7:0] b);
        cyc(1);
        port_wr    = 1'b1;
        port_wdata = b | hi;
        cyc(1);
        port_wr    = 1'b0;
    endtask : wr

    // command triplet a, b, a: strobe edge on the middle write only when b alone sets bit 5
    task automatic wr3(input logic [7:0] a, input logic [7:0] b);
        wr(a);
        wr(b);
        wr(a);
    endtask : wr3

    task automatic rd(input logic [2:0] a);
        cyc(1);
        port_addr = a;
        port_rd   = 1'b1;
        cyc(1);
        port_rd   = 1'b0;
        port_addr = 3'h2;
    endtask : rd

    task automatic waitv(input logic v, output int k);
        k = 0;
        while (timed_pulse_q !== v) begin
            cyc(1);
            k++;
            if (k > 5000) begin
                miscompares++;
                $display("mismatch at %0t: timed pulse stuck", $time);
                summarize();
            end
        end
    endtask : waitv

    task automatic meas(input int exp_half, input string what);
        int hn;
        int ln;
        waitv(1'b0, hn);
        waitv(1'b1, hn);
        waitv(1'b0, hn);
        waitv(1'b1, ln);
        chk(40'(hn), 40'(exp_half), what);
        chk(40'(ln), 40'(exp_half), what);
    endtask : meas

    function automatic logic [7:0] bcd(input int v);
        return {4'(v / 10), 4'(v % 10)};
    endfunction : bcd

    function automatic logic [39:0] tv(input int s, m, hr, d, w, mo);
        return {4'(mo), 4'(w), bcd(d), bcd(hr), bcd(m), bcd(s)};
    endfunction : tv

    task automatic wt(input logic [39:0] v);
        logic [7:0] b;
        wr3(8'h04, 8'h24);
        for (int i = 0; i < 40; i++) begin
            b = {7'h00, v[i]};
            wr(b);
            wr(b | 8'h02);
            wr(b);
        end
        wr3(8'h08, 8'h28);
    endtask : wt

    task automatic rt(output logic [39:0] v);
        wr3(8'h0C, 8'h2C);
        wr3(8'h24, 8'h04);
        for (int i = 0; i < 40; i++) begin
            cyc(3);
            v[i] = port_rdata_q[0];
            rd(3'h2);
            wr(8'h02);
            wr(8'h00);
        end
    endtask : rt

    initial begin
        clk_sys     = 1'b0;
        rst_n       = 1'b0;
        port_addr   = 3'h2;
        port_wr     = 1'b0;
        port_rd     = 1'b0;
        port_wdata  = 8'h00;
        miscompares = 0;
        comparisons = 0;
        n           = $urandom(42);
        hi          = {2'($urandom()), 6'h00};
        repeat (4) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        cyc(1);
        chk(40'(port_rdata_q), 40'h0, "read byte after reset");
        chk(40'(request_line_seven_q), 40'h0, "request after reset");
        meas(1024, "test mode half period");
        endt("reset");
        // clock commands before a rate is chosen must be ignored
        wt(tv(12, 34, 5, 6, 1, 2));
        wr3(8'h30, 8'h10);
        rt(got);
        chk(got, scc_pkg::TIME_RESET, "time kept in test mode");
        endt("test mode");
        for (int i = 0; i < 5; i++) begin
            wr3(sel_a[i], sel_b[i]);
            meas(half[i], "pulse half period");
        end
        endt("rates");
        waitv(1'b0, n);
        rd(3'h2);
        chk(40'(request_line_seven_q), 40'h0, "request after read");
        waitv(1'b1, n);
        chk(40'(request_line_seven_q), 40'h1, "request on pulse rise");
        cyc(2);
        chk(40'(port_rdata_q[1]), 40'h1, "pulse level high on bit 1");
        waitv(1'b0, n);
        chk(40'(request_line_seven_q), 40'h1, "request held after fall");
        rd(3'h3);
        chk(40'(request_line_seven_q), 40'h1, "read of other port");
        rd(3'h2);
        chk(40'(request_line_seven_q), 40'h0, "read clears request");
        chk(40'(port_rdata_q[1]), 40'h0, "pulse level low on bit 1");
        waitv(1'b1, n);
        rst_n = 1'b0;
        #1;
        chk(40'(request_line_seven_q), 40'h0, "reset clears request");
        cyc(4);
        rst_n = 1'b1;
        endt("request");
        wr3(8'h34, 8'h14);
        for (int i = 0; i < 4; i++) begin
            t = tv($urandom % 60, $urandom % 60, $urandom % 24, 1 + $urandom % 31, $urandom % 7, $urandom % 12);
            if (i == 0) begin
                t = tv(59, 59, 23, 31, 6, 11);
            end
            wt(t);
            rt(got);
            chk(got, t, "time read back");
        end
        endt("readback");
        // one second later: day 31 of a short month rolls into the next month
        wt(tv(59, 59, 23, 31, 6, 3));
        cyc(66000);
        rt(got);
        chk(got, tv(0, 0, 0, 1, 0, 4), "advance past day 31");
        endt("advance");
        summarize();
    end
endmodule : scc_clock_port_tb
